//--- rtl/cma_if.sv
// Token link and status-register port between requester and target
`timescale 1ns/1ps
`default_nettype none
interface cma_if;
	logic        req_valid;
	logic        req_ready;
	logic        req_ctrl;
	logic [7:0]  req_data;
	logic [31:0] req_dest;
	logic        rsp_valid;
	logic        rsp_ready;
	logic        rsp_ctrl;
	logic [7:0]  rsp_data;
	logic [23:0] rsp_dest;
	logic        ps_req;
	logic        ps_we;
	logic [31:0] ps_rid;
	logic [31:0] ps_wdata;
	logic        ps_ack;
	logic        ps_err;
	logic [31:0] ps_rdata;

	modport target (
		input  req_valid, req_ctrl, req_data, req_dest, rsp_ready,
		input  ps_req, ps_we, ps_rid, ps_wdata,
		output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest,
		output ps_ack, ps_err, ps_rdata
	);

	modport requester (
		output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
		output ps_req, ps_we, ps_rid, ps_wdata,
		input  req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest,
		input  ps_ack, ps_err, ps_rdata
	);
endinterface
`default_nettype wire

//--- rtl/cma_pkg.sv
// Shared constants and types for configuration message access
package cma_pkg;

	// Control token values
	localparam logic [7:0]  CT_END      = 8'h01;
	localparam logic [7:0]  CT_ACK      = 8'h03;
	localparam logic [7:0]  CT_NACK     = 8'h04;
	localparam logic [7:0]  CT_CFG_WR   = 8'hc0;
	localparam logic [7:0]  CT_CFG_RD   = 8'hc1;
	localparam logic [7:0]  CT_PER_WR   = 8'h24;
	localparam logic [7:0]  CT_PER_RD   = 8'h25;

	// Destination and resource identifier layouts
	localparam logic [7:0]  PS_RID_LOW  = 8'h0c;
	localparam int          PS_SHIFT    = 8;
	localparam logic [15:0] TILE_LOW    = 16'hc20c;
	localparam logic [15:0] NODE_LOW    = 16'hc30c;
	localparam logic [7:0]  PER_LOW     = 8'h02;

	// Field lengths in byte tokens
	localparam logic [2:0]  RID_BYTES   = 3'h3;
	localparam logic [2:0]  REG_BYTES   = 3'h2;
	localparam logic [2:0]  DATA_BYTES  = 3'h4;
	localparam logic [7:0]  PSIZE_MAX   = 8'h04;

	// Token positions in a request
	localparam logic [8:0]  POS_REG     = 9'h004;
	localparam logic [8:0]  POS_CFG_DAT = 9'h006;
	localparam logic [8:0]  POS_SIZE    = 9'h005;
	localparam logic [8:0]  LEN_CFG_WR  = 9'h00b;
	localparam logic [8:0]  LEN_RD      = 9'h007;

	// Value of every register after reset
	localparam logic [31:0] RST_WORD    = 32'h0;

	typedef enum logic [2:0] {
		KIND_TILE_WR,
		KIND_TILE_RD,
		KIND_NODE_WR,
		KIND_NODE_RD,
		KIND_PER_WR,
		KIND_PER_RD,
		KIND_PS_WR,
		KIND_PS_RD
	} cma_kind_t;

endpackage

//--- rtl/cma_requester.sv
// Requesting channel end: builds request messages and collects replies
`timescale 1ns/1ps
`default_nettype none
module cma_requester (
	input  wire logic               clk,
	input  wire logic               nrst,
	cma_if.requester                lnk,
	input  wire logic               cmd_valid,
	input  wire cma_pkg::cma_kind_t cmd_kind,
	input  wire logic [15:0]        cmd_target,
	input  wire logic [7:0]         cmd_periph,
	input  wire logic [15:0]        cmd_reg,
	input  wire logic [7:0]         cmd_size,
	input  wire logic [31:0]        cmd_wdata,
	input  wire logic [23:0]        cmd_reply_id,
	output logic                    cmd_ready,
	output logic                    res_done,
	output logic                    res_ok,
	output logic [31:0]             res_rdata
);

	typedef enum logic [1:0] {R_IDLE, R_SEND, R_WAIT, R_PS} cma_rst_t;

	typedef struct packed {
		cma_rst_t           st;
		cma_pkg::cma_kind_t kind;
		logic [8:0]         idx;
		logic [8:0]         len;
		logic [31:0]        dest;
		logic [23:0]        rid;
		logic [15:0]        regn;
		logic [7:0]         size;
		logic [31:0]        wdata;
		logic               req_valid;
		logic               req_ctrl;
		logic [7:0]         req_data;
		logic               rsp_ready;
		logic               ps_req;
		logic               ps_we;
		logic [31:0]        ps_rid;
		logic [31:0]        ps_wdata;
		logic               cmd_ready;
		logic               done;
		logic               ok;
		logic [31:0]        rdata;
	} cma_rstate_t;

	cma_rstate_t r;
	cma_rstate_t v;

	// Token at position i of the request held in s
	function automatic logic [8:0] tok_at(input cma_rstate_t s, input logic [8:0] i);
		logic        per;
		logic [31:0] sh;
		logic [8:0]  k;
		per = (s.kind == cma_pkg::KIND_PER_WR) || (s.kind == cma_pkg::KIND_PER_RD);
		sh  = s.wdata;
		k   = 9'(i - cma_pkg::POS_CFG_DAT);
		if (i == 9'h000) begin
			case (s.kind)
				cma_pkg::KIND_TILE_WR, cma_pkg::KIND_NODE_WR: return {1'b1, cma_pkg::CT_CFG_WR};
				cma_pkg::KIND_TILE_RD, cma_pkg::KIND_NODE_RD: return {1'b1, cma_pkg::CT_CFG_RD};
				cma_pkg::KIND_PER_WR:                         return {1'b1, cma_pkg::CT_PER_WR};
				default:                                      return {1'b1, cma_pkg::CT_PER_RD};
			endcase
		end
		if (i == s.len - 9'h001) begin
			return {1'b1, cma_pkg::CT_END};
		end
		if (i < cma_pkg::POS_REG) begin
			sh = {8'h00, s.rid} >> (8 * (3 - int'(i)));
			return {1'b0, sh[7:0]};
		end
		if (per) begin
			if (i == cma_pkg::POS_REG) begin
				return {1'b0, s.regn[7:0]};
			end
			if (i == cma_pkg::POS_SIZE) begin
				return {1'b0, s.size};
			end
			// With a size above four every data byte goes out as zero
			if (int'(k) < int'(s.size) && int'(s.size) <= 4) begin
				sh = s.wdata >> (8 * (int'(s.size) - 1 - int'(k)));
				return {1'b0, sh[7:0]};
			end
			return 9'h000;
		end
		if (i == cma_pkg::POS_REG) begin
			return {1'b0, s.regn[15:8]};
		end
		if (i == cma_pkg::POS_SIZE) begin
			return {1'b0, s.regn[7:0]};
		end
		sh = s.wdata >> (8 * (3 - int'(k[1:0])));
		return {1'b0, sh[7:0]};
	endfunction

	always_comb begin
		v = r;
		v.done = 1'b0;
		case (r.st)
			R_IDLE: begin
				if (cmd_valid) begin
					v.kind  = cmd_kind;
					v.rid   = cmd_reply_id;
					v.regn  = cmd_reg;
					v.size  = cmd_size;
					v.wdata = cmd_wdata;
					v.idx   = 9'h000;
					case (cmd_kind)
						cma_pkg::KIND_TILE_WR, cma_pkg::KIND_TILE_RD:
							v.dest = {cmd_target, cma_pkg::TILE_LOW};
						cma_pkg::KIND_NODE_WR, cma_pkg::KIND_NODE_RD:
							v.dest = {cmd_target, cma_pkg::NODE_LOW};
						default:
							v.dest = {cmd_target, cmd_periph, cma_pkg::PER_LOW};
					endcase
					case (cmd_kind)
						cma_pkg::KIND_TILE_WR, cma_pkg::KIND_NODE_WR: v.len = cma_pkg::LEN_CFG_WR;
						cma_pkg::KIND_PER_WR: v.len = 9'(cma_pkg::LEN_RD + 9'(cmd_size));
						default:              v.len = cma_pkg::LEN_RD;
					endcase
					if (cmd_kind == cma_pkg::KIND_PS_WR || cmd_kind == cma_pkg::KIND_PS_RD) begin
						v.ps_req   = 1'b1;
						v.ps_we    = (cmd_kind == cma_pkg::KIND_PS_WR);
						v.ps_rid   = (32'(cmd_reg) << cma_pkg::PS_SHIFT) | 32'(cma_pkg::PS_RID_LOW);
						v.ps_wdata = cmd_wdata;
						v.st       = R_PS;
					end else begin
						v.st = R_SEND;
					end
				end
			end
			R_SEND: begin
				if (!r.req_valid || lnk.req_ready) begin
					if (r.idx == r.len) begin
						v.req_valid = 1'b0;
						v.rsp_ready = 1'b1;
						v.rdata     = cma_pkg::RST_WORD;
						v.st        = R_WAIT;
					end else begin
						{v.req_ctrl, v.req_data} = tok_at(r, r.idx);
						v.req_valid = 1'b1;
						v.idx       = 9'(r.idx + 9'h001);
					end
				end
			end
			R_WAIT: begin
				// Replies for another channel end are not ours and are dropped
				if (lnk.rsp_valid && lnk.rsp_dest == r.rid) begin
					if (!lnk.rsp_ctrl) begin
						v.rdata = {r.rdata[23:0], lnk.rsp_data};
					end else if (lnk.rsp_data == cma_pkg::CT_END) begin
						v.done      = 1'b1;
						v.rsp_ready = 1'b0;
						v.st        = R_IDLE;
					end else begin
						v.ok = (lnk.rsp_data == cma_pkg::CT_ACK);
					end
				end
			end
			R_PS: begin
				v.ps_req = 1'b0;
				if (lnk.ps_ack) begin
					v.ok    = !lnk.ps_err;
					v.rdata = lnk.ps_rdata;
					v.done  = 1'b1;
					v.st    = R_IDLE;
				end
			end
			default: v.st = R_IDLE;
		endcase
		v.cmd_ready = (v.st == R_IDLE);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.st <= R_IDLE;
			r.kind <= cma_pkg::KIND_TILE_WR;
			r.cmd_ready <= 1'b1;
		end else begin
			r <= v;
		end
	end

	assign lnk.req_valid = r.req_valid;
	assign lnk.req_ctrl  = r.req_ctrl;
	assign lnk.req_data  = r.req_data;
	assign lnk.req_dest  = r.dest;
	assign lnk.rsp_ready = r.rsp_ready;
	assign lnk.ps_req    = r.ps_req;
	assign lnk.ps_we     = r.ps_we;
	assign lnk.ps_rid    = r.ps_rid;
	assign lnk.ps_wdata  = r.ps_wdata;
	assign cmd_ready     = r.cmd_ready;
	assign res_done      = r.done;
	assign res_ok        = r.ok;
	assign res_rdata     = r.rdata;

endmodule
`default_nettype wire

//--- rtl/cma_target.sv
// Configuration target: decodes token messages and status-register accesses
// Summary of operation
// - Status resource id is number shifted, low 0x0C
// - Status read/write moves one whole word
// - Tile destination: tile id over C20C
// - Node destination: node id over C30C
// - Peripheral destination: node, peripheral, then 02
// - Write: 192, reply id, register, data, 1
// - Read: 193, reply id, register, 1
// - Write reply: 3,1 success; 4,1 failure
// - Read reply: 3, word, 1; else 4,1
// - Peripheral write: 36, id, reg, size, bytes, 1
// - Peripheral read: 37, id, reg, size, 1
// - Peripheral read reply: 3, bytes, 1; else 4,1
`timescale 1ns/1ps
`default_nettype none
module cma_target #(
	parameter logic [15:0] TILE_ID   = 16'h0000,
	parameter logic [15:0] NODE_ID   = 16'h0001,
	parameter logic [7:0]  PERIPH_ID = 8'h01,
	parameter int          NPS       = 16,
	parameter int          NTILE     = 16,
	parameter int          NNODE     = 16,
	parameter int          NPER      = 32
) (
	input  wire logic clk,
	input  wire logic nrst,
	cma_if.target     lnk
);

	typedef enum logic [2:0] {S_IDLE, S_RID, S_REG, S_SIZE, S_DATA, S_END, S_RESP} cma_tst_t;
	typedef enum logic [1:0] {CLS_NONE, CLS_TILE, CLS_NODE, CLS_PER} cma_cls_t;

	typedef struct packed {
		cma_tst_t                   st;
		cma_cls_t                   cls;
		logic                       wr;
		logic                       err;
		logic [2:0]                 cnt;
		logic [23:0]                rid;
		logic [15:0]                regn;
		logic [7:0]                 size;
		logic [31:0]                wdata;
		logic                       ok;
		logic [31:0]                rword;
		logic [2:0]                 rn;
		logic [2:0]                 rsp_idx;
		logic                       req_ready;
		logic                       rsp_valid;
		logic                       rsp_ctrl;
		logic [7:0]                 rsp_data;
		logic [23:0]                rsp_dest;
		logic                       ps_ack;
		logic                       ps_err;
		logic [31:0]                ps_rdata;
		logic [NPS-1:0][31:0]       psr;
		logic [NTILE-1:0][31:0]     tile;
		logic [NNODE-1:0][31:0]     node;
		logic [NPER-1:0][7:0]       per;
	} cma_tstate_t;

	cma_tstate_t r;
	cma_tstate_t v;
	logic        take;
	logic        addr_ok;
	logic [23:0] ps_num;

	// Which register class a destination word selects
	function automatic cma_cls_t dest_class(input logic [31:0] d);
		if (d[15:0] == cma_pkg::TILE_LOW && d[31:16] == TILE_ID) begin
			return CLS_TILE;
		end
		if (d[15:0] == cma_pkg::NODE_LOW && d[31:16] == NODE_ID) begin
			return CLS_NODE;
		end
		if (d[7:0] == cma_pkg::PER_LOW && d[15:8] == PERIPH_ID && d[31:16] == NODE_ID) begin
			return CLS_PER;
		end
		return CLS_NONE;
	endfunction

	assign take   = lnk.req_valid & r.req_ready;
	assign ps_num = lnk.ps_rid[31:cma_pkg::PS_SHIFT];

	always_comb begin
		v = r;
		v.ps_ack = 1'b0;
		addr_ok = 1'b0;
		case (r.cls)
			CLS_TILE: addr_ok = (r.regn < 16'(NTILE));
			CLS_NODE: addr_ok = (r.regn < 16'(NNODE));
			CLS_PER:  addr_ok = 1'b1;
			default:  addr_ok = 1'b0;
		endcase

		// Status registers: one word per access, id checked before use
		if (lnk.ps_req) begin
			v.ps_ack = 1'b1;
			v.ps_err = (lnk.ps_rid[7:0] != cma_pkg::PS_RID_LOW) || (ps_num >= 24'(NPS));
			if (!v.ps_err) begin
				if (lnk.ps_we) begin
					v.psr[ps_num] = lnk.ps_wdata;
				end else begin
					v.ps_rdata = r.psr[ps_num];
				end
			end else begin
				v.ps_rdata = cma_pkg::RST_WORD;
			end
		end

		case (r.st)
			S_IDLE: begin
				// Stray data or end tokens between messages are dropped
				if (take && lnk.req_ctrl && lnk.req_data != cma_pkg::CT_END) begin
					v.cls   = dest_class(lnk.req_dest);
					v.cnt   = 3'h0;
					v.rid   = 24'h0;
					v.regn  = 16'h0;
					v.size  = 8'h0;
					v.wdata = cma_pkg::RST_WORD;
					v.wr    = (lnk.req_data == cma_pkg::CT_CFG_WR) || (lnk.req_data == cma_pkg::CT_PER_WR);
					case (lnk.req_data)
						cma_pkg::CT_CFG_WR,
						cma_pkg::CT_CFG_RD: v.err = !(v.cls == CLS_TILE || v.cls == CLS_NODE);
						cma_pkg::CT_PER_WR,
						cma_pkg::CT_PER_RD: v.err = (v.cls != CLS_PER);
						default:            v.err = 1'b1;
					endcase
					// Reply id is still gathered so that a refusal reaches its sender
					v.st = S_RID;
				end
			end
			S_RESP: begin
				if (!r.rsp_valid || lnk.rsp_ready) begin
					if (r.rsp_idx == r.rn + 3'h2) begin
						v.rsp_valid = 1'b0;
						v.req_ready = 1'b1;
						v.st        = S_IDLE;
					end else begin
						v.rsp_valid = 1'b1;
						v.rsp_idx   = 3'(r.rsp_idx + 3'h1);
						if (r.rsp_idx == 3'h0) begin
							v.rsp_ctrl = 1'b1;
							v.rsp_data = r.ok ? cma_pkg::CT_ACK : cma_pkg::CT_NACK;
						end else if (r.rsp_idx <= r.rn) begin
							v.rsp_ctrl = 1'b0;
							v.rsp_data = r.rword[31:24];
							v.rword    = {r.rword[23:0], 8'h00};
						end else begin
							v.rsp_ctrl = 1'b1;
							v.rsp_data = cma_pkg::CT_END;
						end
					end
				end
			end
			default: begin
				if (take && lnk.req_ctrl && lnk.req_data == cma_pkg::CT_END) begin
					// Early end or any earlier fault gives a failure reply
					v.ok    = !r.err && (r.st == S_END) && addr_ok;
					v.rn    = 3'h0;
					v.rword = cma_pkg::RST_WORD;
					if (v.ok && r.wr) begin
						case (r.cls)
							CLS_TILE: v.tile[r.regn] = r.wdata;
							CLS_NODE: v.node[r.regn] = r.wdata;
							default: begin
								for (int k = 0; k < 4; k++) begin
									if (k < int'(r.size)) begin
										v.per[int'(r.regn[7:0]) + k] = r.wdata[8*(int'(r.size)-1-k) +: 8];
									end
								end
							end
						endcase
					end else if (v.ok) begin
						case (r.cls)
							CLS_TILE: v.rword = r.tile[r.regn];
							CLS_NODE: v.rword = r.node[r.regn];
							default: begin
								for (int k = 0; k < 4; k++) begin
									if (k < int'(r.size)) begin
										v.rword[31-8*k -: 8] = r.per[int'(r.regn[7:0]) + k];
									end
								end
							end
						endcase
						v.rn = (r.cls == CLS_PER) ? r.size[2:0] : cma_pkg::DATA_BYTES;
					end
					v.rsp_dest  = r.rid;
					v.rsp_idx   = 3'h0;
					v.req_ready = 1'b0;
					v.st        = S_RESP;
				end else if (take && lnk.req_ctrl) begin
					// Unexpected control token: skip to the end token
					v.err = 1'b1;
					v.st  = S_END;
				end else if (take) begin
					case (r.st)
						S_RID: begin
							v.rid = {r.rid[15:0], lnk.req_data};
							v.cnt = 3'(r.cnt + 3'h1);
							if (v.cnt == cma_pkg::RID_BYTES) begin
								v.cnt = 3'h0;
								v.st  = S_REG;
							end
						end
						S_REG: begin
							v.regn = {r.regn[7:0], lnk.req_data};
							v.cnt  = 3'(r.cnt + 3'h1);
							if (r.cls == CLS_PER) begin
								v.cnt = 3'h0;
								v.st  = S_SIZE;
							end else if (v.cnt == cma_pkg::REG_BYTES) begin
								v.cnt = 3'h0;
								v.st  = r.wr ? S_DATA : S_END;
							end
						end
						S_SIZE: begin
							v.size = lnk.req_data;
							if (lnk.req_data == 8'h00 || lnk.req_data > cma_pkg::PSIZE_MAX ||
							    (9'(r.regn[7:0]) + 9'(lnk.req_data)) > 9'(NPER)) begin
								v.err = 1'b1;
								v.st  = S_END;
							end else begin
								v.st = r.wr ? S_DATA : S_END;
							end
						end
						S_DATA: begin
							v.wdata = {r.wdata[23:0], lnk.req_data};
							v.cnt   = 3'(r.cnt + 3'h1);
							if (v.cnt == ((r.cls == CLS_PER) ? r.size[2:0] : cma_pkg::DATA_BYTES)) begin
								v.st = S_END;
							end
						end
						default: v.err = 1'b1;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.st <= S_IDLE;
			r.cls <= CLS_NONE;
			r.req_ready <= 1'b1;
		end else begin
			r <= v;
		end
	end

	assign lnk.req_ready = r.req_ready;
	assign lnk.rsp_valid = r.rsp_valid;
	assign lnk.rsp_ctrl  = r.rsp_ctrl;
	assign lnk.rsp_data  = r.rsp_data;
	assign lnk.rsp_dest  = r.rsp_dest;
	assign lnk.ps_ack    = r.ps_ack;
	assign lnk.ps_err    = r.ps_err;
	assign lnk.ps_rdata  = r.ps_rdata;

endmodule
`default_nettype wire

//--- tb/cma_properties.sv
// Concurrent checks on the token link and status port between the two ends
`timescale 1ns/1ps
`default_nettype none
module cma_properties #(
	parameter int NPS = 16
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        req_ctrl,
	input wire logic [7:0]  req_data,
	input wire logic [31:0] req_dest,
	input wire logic        rsp_valid,
	input wire logic        rsp_ready,
	input wire logic        rsp_ctrl,
	input wire logic [7:0]  rsp_data,
	input wire logic [23:0] rsp_dest,
	input wire logic        ps_req,
	input wire logic [31:0] ps_rid,
	input wire logic        ps_ack,
	input wire logic        ps_err
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	logic end_take;
	logic ps_bad;
	assign end_take = req_valid && req_ready && req_ctrl && req_data == cma_pkg::CT_END;
	assign ps_bad   = ps_rid[7:0] != cma_pkg::PS_RID_LOW || ps_rid[31:8] >= NPS;

	ps_ack_due_a: assert property (ps_req |=> ps_ack)
		else $error("status ack not one cycle after request");
	ps_ack_cause_a: assert property (ps_ack |-> $past(ps_req))
		else $error("status ack without request");
	ps_bad_id_a: assert property (ps_req && ps_bad |=> ps_err)
		else $error("bad status id not refused");
	ps_good_id_a: assert property (ps_req && !ps_bad |=> !ps_err)
		else $error("good status id refused");
	rsp_open_a: assert property ($rose(rsp_valid) |-> rsp_ctrl && (rsp_data == cma_pkg::CT_ACK
		|| rsp_data == cma_pkg::CT_NACK))
		else $error("reply opens without ack or nack");
	rsp_close_a: assert property ($fell(rsp_valid) |-> $past(rsp_ctrl) && $past(rsp_data) == cma_pkg::CT_END)
		else $error("reply not closed by end token");
	nack_end_a: assert property (rsp_valid && rsp_ready && rsp_ctrl && rsp_data == cma_pkg::CT_NACK
		|=> rsp_valid && rsp_ctrl && rsp_data == cma_pkg::CT_END)
		else $error("nack not followed by end token");
	reply_due_a: assert property (end_take |=> !req_ready ##[0:2] rsp_valid)
		else $error("no reply after end of request");
	dest_hold_a: assert property (rsp_valid && $past(rsp_valid) |-> $stable(rsp_dest))
		else $error("reply destination moved mid reply");
	cfg_dest_a: assert property (req_valid && req_ctrl && (req_data == cma_pkg::CT_CFG_WR
		|| req_data == cma_pkg::CT_CFG_RD) |-> req_dest[15:0] == cma_pkg::TILE_LOW
		|| req_dest[15:0] == cma_pkg::NODE_LOW)
		else $error("config request with wrong destination");
	per_dest_a: assert property (req_valid && req_ctrl && (req_data == cma_pkg::CT_PER_WR
		|| req_data == cma_pkg::CT_PER_RD) |-> req_dest[7:0] == cma_pkg::PER_LOW)
		else $error("peripheral request with wrong destination");

	cover property (ps_req ##1 ps_err);
	cover property ($rose(rsp_valid) && rsp_data == cma_pkg::CT_NACK);
	cover property (end_take ##[1:8] $fell(rsp_valid));
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench joining requester and target across the token link
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {
		cma_pkg::cma_kind_t k;
		logic [15:0]        t;
		logic [7:0]         p;
		logic [15:0]        r;
		logic [7:0]         s;
		logic [31:0]        w;
		logic               ok;
		logic               rd;
		logic [31:0]        x;
	} cma_row_t;

	logic               clk;
	logic               nrst;
	logic               cmd_valid;
	cma_pkg::cma_kind_t cmd_kind;
	logic [15:0]        cmd_target;
	logic [7:0]         cmd_periph;
	logic [15:0]        cmd_reg;
	logic [7:0]         cmd_size;
	logic [31:0]        cmd_wdata;
	logic [23:0]        cmd_reply_id;
	logic               cmd_ready;
	logic               res_done;
	logic               res_ok;
	logic [31:0]        res_rdata;
	logic [31:0]        dest_seen;
	logic [23:0]        rdest_seen;
	logic [8:0]         req_q[$];
	logic [8:0]         rsp_q[$];
	int                 num_errors;
	int                 checked;
	int                 cycles;
	// Config write of 0x0badf00d to reg 1, reply id 123456
	logic [8:0]         ex[11] = '{9'h1c0, 9'h012, 9'h034, 9'h056, 9'h000, 9'h001,
		9'h00b, 9'h0ad, 9'h0f0, 9'h00d, 9'h101};
	// Peripheral bytes land in register order, so reg 5 reads the low byte
	// Write to a foreign tile is refused yet answered, and leaves reg 2 alone
	cma_row_t           rows[17] = '{
		'{cma_pkg::KIND_TILE_WR, 16'h0000, 8'h00, 16'h0002, 8'h00, 32'h11223344, 1'b1, 1'b0, 32'h0},
		'{cma_pkg::KIND_TILE_WR, 16'h0005, 8'h00, 16'h0002, 8'h00, 32'hdeadbeef, 1'b0, 1'b0, 32'h0},
		'{cma_pkg::KIND_TILE_RD, 16'h0000, 8'h00, 16'h0002, 8'h00, 32'h0, 1'b1, 1'b1, 32'h11223344},
		'{cma_pkg::KIND_NODE_WR, 16'h0001, 8'h00, 16'h0005, 8'h00, 32'ha5a55a5a, 1'b1, 1'b0, 32'h0},
		'{cma_pkg::KIND_NODE_RD, 16'h0001, 8'h00, 16'h0005, 8'h00, 32'h0, 1'b1, 1'b1, 32'ha5a55a5a},
		'{cma_pkg::KIND_TILE_RD, 16'h0000, 8'h00, 16'h0005, 8'h00, 32'h0, 1'b1, 1'b1, 32'h0},
		'{cma_pkg::KIND_PER_WR, 16'h0001, 8'h01, 16'h0004, 8'h02, 32'h0000beef, 1'b1, 1'b0, 32'h0},
		'{cma_pkg::KIND_PER_RD, 16'h0001, 8'h01, 16'h0004, 8'h02, 32'h0, 1'b1, 1'b1, 32'h0000beef},
		'{cma_pkg::KIND_PER_RD, 16'h0001, 8'h01, 16'h0005, 8'h01, 32'h0, 1'b1, 1'b1, 32'h000000ef},
		'{cma_pkg::KIND_PS_WR, 16'h0000, 8'h00, 16'h0003, 8'h00, 32'hcafe0001, 1'b1, 1'b0, 32'h0},
		'{cma_pkg::KIND_PS_RD, 16'h0000, 8'h00, 16'h0003, 8'h00, 32'h0, 1'b1, 1'b1, 32'hcafe0001},
		'{cma_pkg::KIND_TILE_WR, 16'h0000, 8'h00, 16'h0010, 8'h00, 32'h1, 1'b0, 1'b0, 32'h0},
		'{cma_pkg::KIND_NODE_RD, 16'h0001, 8'h00, 16'h0010, 8'h00, 32'h0, 1'b0, 1'b0, 32'h0},
		'{cma_pkg::KIND_PER_WR, 16'h0001, 8'h01, 16'h0004, 8'h05, 32'h12345678, 1'b0, 1'b0, 32'h0},
		'{cma_pkg::KIND_PER_RD, 16'h0001, 8'h01, 16'h0004, 8'h02, 32'h0, 1'b1, 1'b1, 32'h0000beef},
		'{cma_pkg::KIND_PS_WR, 16'h0000, 8'h00, 16'h0010, 8'h00, 32'h5, 1'b0, 1'b0, 32'h0},
		'{cma_pkg::KIND_PS_RD, 16'h0000, 8'h00, 16'h0003, 8'h00, 32'h0, 1'b1, 1'b1, 32'hcafe0001}
	};

	cma_if lnk();
	cma_target cma_target_i (.clk(clk), .nrst(nrst), .lnk(lnk.target));
	cma_requester cma_requester_i (.clk(clk), .nrst(nrst), .lnk(lnk.requester), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_target(cmd_target), .cmd_periph(cmd_periph), .cmd_reg(cmd_reg),
		.cmd_size(cmd_size), .cmd_wdata(cmd_wdata), .cmd_reply_id(cmd_reply_id), .cmd_ready(cmd_ready),
		.res_done(res_done), .res_ok(res_ok), .res_rdata(res_rdata));
	cma_properties #(.NPS(16)) cma_properties_i (.clk(clk), .nrst(nrst), .req_valid(lnk.req_valid),
		.req_ready(lnk.req_ready), .req_ctrl(lnk.req_ctrl), .req_data(lnk.req_data), .req_dest(lnk.req_dest),
		.rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready), .rsp_ctrl(lnk.rsp_ctrl),
		.rsp_data(lnk.rsp_data), .rsp_dest(lnk.rsp_dest), .ps_req(lnk.ps_req), .ps_rid(lnk.ps_rid),
		.ps_ack(lnk.ps_ack), .ps_err(lnk.ps_err));

	task automatic end_sim();
		if (num_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
		checked++;
	endtask

	// Command held from a falling edge until a rising edge that sees ready
	task automatic run(input cma_row_t r, input logic [23:0] rid);
		int n;
		@(negedge clk);
		cmd_valid    = 1'b1;
		cmd_kind     = r.k;
		cmd_target   = r.t;
		cmd_periph   = r.p;
		cmd_reg      = r.r;
		cmd_size     = r.s;
		cmd_wdata    = r.w;
		cmd_reply_id = rid;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (res_done !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(res_done, 1'b1);
		chk(res_ok, r.ok);
		if (r.rd) begin
			chk(res_rdata, r.x);
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Link monitor; the timeout ceiling is far above the expected run
	always @(posedge clk) begin
		if (lnk.req_valid && lnk.req_ready) begin
			req_q.push_back({lnk.req_ctrl, lnk.req_data});
			if (lnk.req_ctrl && lnk.req_data == cma_pkg::CT_CFG_WR) begin
				dest_seen = lnk.req_dest;
			end
		end
		if (lnk.rsp_valid && lnk.rsp_ready) begin
			rsp_q.push_back({lnk.rsp_ctrl, lnk.rsp_data});
			rdest_seen = lnk.rsp_dest;
		end
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = cma_pkg::KIND_TILE_WR;
		cmd_target = 16'h0;
		cmd_periph = 8'h0;
		cmd_reg = 16'h0;
		cmd_size = 8'h0;
		cmd_wdata = 32'h0;
		cmd_reply_id = 24'h0;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (4) @(negedge clk);
		chk(cmd_ready, 1'b1);
		chk(lnk.req_ready, 1'b1);
		chk(lnk.rsp_valid, 1'b0);
		nrst = 1'b1;
		for (int i = 0; i < 17; i++) begin
			run(rows[i], 24'h0a0000 | 24'(i));
		end
		req_q.delete();
		rsp_q.delete();
		run('{cma_pkg::KIND_TILE_WR, 16'h0, 8'h0, 16'h0001, 8'h0, 32'h0badf00d, 1'b1, 1'b0, 32'h0}, 24'h123456);
		chk(req_q.size(), 11);
		for (int k = 0; k < 11; k++) begin
			chk(req_q[k], ex[k]);
		end
		chk(rsp_q.size(), 2);
		chk(rsp_q[0], 9'h103);
		chk(rsp_q[1], 9'h101);
		chk(dest_seen, 32'h0000c20c);
		chk(rdest_seen, 24'h123456);
		// Second reset mid-run; tile reg 2 and status reg 3 then read back as zero
		@(negedge clk);
		nrst = 1'b0;
		@(negedge clk);
		chk(lnk.rsp_valid, 1'b0);
		nrst = 1'b1;
		run('{cma_pkg::KIND_TILE_RD, 16'h0, 8'h0, 16'h0002, 8'h0, 32'h0, 1'b1, 1'b1, 32'h0}, 24'h0b0001);
		run('{cma_pkg::KIND_PS_RD, 16'h0, 8'h0, 16'h0003, 8'h0, 32'h0, 1'b1, 1'b1, 32'h0}, 24'h0b0002);
		end_sim();
	end
endmodule
`default_nettype wire
